// ===== verilog/csar_pkg.sv
// Constants shared by the charger state, loop status and limit flag register bank
package csar_pkg;

  // ----------------------------------------------------------------
  // Register map (serial port sub-addresses)
  // ----------------------------------------------------------------
  localparam int CSAR_REG_W = 16;
  localparam logic [7:0] CSAR_OFS_STATE = 8'h34;
  localparam logic [7:0] CSAR_OFS_LOOP = 8'h35;
  localparam logic [7:0] CSAR_OFS_FLAGS = 8'h36;
  localparam logic [15:0] CSAR_READ_UNMAPPED = 16'h0000;

  // ----------------------------------------------------------------
  // Charger state bits; the phase code equals the bit position
  // ----------------------------------------------------------------
  localparam int CSAR_ST_EQUALIZE = 10;
  localparam int CSAR_ST_ABSORB = 9;
  localparam int CSAR_ST_SUSPENDED = 8;
  localparam int CSAR_ST_PRECHARGE = 7;
  localparam int CSAR_ST_CONST_CURRENT_VOLTAGE_PHASE = 6;
  localparam int CSAR_ST_THERM_PAUSE = 5;
  localparam int CSAR_ST_TIMER_TERM = 4;
  localparam int CSAR_ST_LOW_CURRENT_TERM = 3;
  localparam int CSAR_ST_MAX_TIME_FAULT = 2;
  localparam int CSAR_ST_BAT_MISSING = 1;
  localparam int CSAR_ST_BAT_SHORTED = 0;
  localparam logic [3:0] CSAR_PH_LAST = 4'ha;
  localparam logic [15:0] CSAR_STATE_ONE = 16'h0001;
  localparam logic [15:0] CSAR_STATE_IMPL = 16'h07ff;

  // ----------------------------------------------------------------
  // Active loop bits
  // ----------------------------------------------------------------
  localparam int CSAR_LOOP_UVCL = 3;
  localparam int CSAR_LOOP_IIN = 2;
  localparam int CSAR_LOOP_ICHARGE = 1;
  localparam int CSAR_LOOP_VCHARGE = 0;

  // ----------------------------------------------------------------
  // Limit flag bits; bit 14 is reserved
  // ----------------------------------------------------------------
  localparam int CSAR_FLG_MEAS_VALID = 15;
  localparam logic [15:0] CSAR_FLAG_IMPL = 16'hbfff;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  localparam logic [6:0] CSAR_DEV_ADDR_DEF = 7'h2a;
  localparam logic [3:0] CSAR_BITS_PER_BYTE = 4'h8;

  typedef enum logic [8:0] {
    CSAR_IDLE = 9'h001,
    CSAR_ADDR = 9'h002,
    CSAR_ACK_ADDR = 9'h004,
    CSAR_SUB = 9'h008,
    CSAR_ACK_SUB = 9'h010,
    CSAR_WR = 9'h020,
    CSAR_ACK_WR = 9'h040,
    CSAR_RD = 9'h080,
    CSAR_RD_ACK = 9'h100
  } csar_port_state_t;

endpackage

// ===== verilog/csar_flag_cell.sv
// One sticky limit flag: enable-gated set, software clear, set beats clear
`timescale 1ns/1ps

module csar_flag_cell (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_set,
  input wire logic i_enable,
  input wire logic i_clear,
  output logic o_flag
);

  logic flag_q;
  logic flag_d;

  // Removing the enable drops the flag; a set in the clearing cycle survives
  assign flag_d = !i_enable ? 1'b0 : (i_set ? 1'b1 : (i_clear ? 1'b0 : flag_q));

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule

// ===== verilog/csar_regs.sv
// Charger state, active loop and sticky limit flag registers behind the serial port
`timescale 1ns/1ps

// Behaviour
// - State register is one-hot in bits 10:0, all zero for a phase code above 10; bits 15:11 read zero.
// - Bits 10..6: equalize, absorb, suspended, precharge, constant current/voltage.
// - Bits 5..3: thermistor pause, timer termination, low-current termination.
// - Bits 2..0: max charge time, missing battery, shorted battery faults.
// - Loop bits are exclusive and show only while in a charging state.
// - Bit 3 input undervoltage loop, bit 2 input current limit loop.
// - Bit 1 charge current loop, bit 0 battery voltage loop.
// - Each limit flag is gated by its bit of the enable input.
// - Writing zero to a limit flag clears it; host acknowledges that way.
// - Limit flags stay set until cleared or disabled, even if cause ends.
// - Bit 15 sets when measurement results become valid.
// - Bit 13 charge count low, bit 12 charge count high.
// - Bit 11 battery voltage low, bit 10 battery voltage high.
// - Bit 9 input voltage low, bit 8 input voltage high.
// - Bit 7 system voltage low, bit 6 system voltage high.
// - Bit 5 input current above its high limit.
// - Bit 4 battery current below its low limit.
// - Bit 3 die temperature above its high limit.
// - Bit 2 battery series resistance above its high limit.
// - Bit 1 cold battery, bit 0 hot battery from thermistor ratio.
module csar_regs
  import csar_pkg::*;
#(
  parameter logic [6:0] P_DEV_ADDR = CSAR_DEV_ADDR_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [3:0] i_charge_phase,
  input wire logic i_uvcl_loop,
  input wire logic i_iin_loop,
  input wire logic i_icharge_loop,
  input wire logic i_vcharge_loop,
  input wire logic [15:0] i_limit_enable,
  input wire logic i_meas_valid,
  input wire logic i_charge_count_low,
  input wire logic i_charge_count_high,
  input wire logic i_battery_volt_low,
  input wire logic i_battery_volt_high,
  input wire logic i_input_volt_low,
  input wire logic i_input_volt_high,
  input wire logic i_system_volt_low,
  input wire logic i_system_volt_high,
  input wire logic i_input_current_high,
  input wire logic i_battery_current_low,
  input wire logic i_chip_heat,
  input wire logic i_series_resistance_high,
  input wire logic i_cold_battery,
  input wire logic i_hot_battery,
  output logic [15:0] o_charger_state_onehot,
  output logic [15:0] o_active_loop_status,
  output logic [15:0] o_measurement_limit_flags
);

  // ----------------------------------------------------------------
  // Pin synchronisers and bus event detection
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_d_q;
  logic sda_m_q, sda_s_q, sda_d_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      {scl_m_q, scl_s_q, scl_d_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_d_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_d_q} <= {i_scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_d_q} <= {i_sda, sda_m_q, sda_s_q};
    end
  end

  wire scl_rise = scl_s_q & ~scl_d_q;
  wire scl_fall = ~scl_s_q & scl_d_q;
  wire start_det = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  wire stop_det = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

  // ----------------------------------------------------------------
  // Serial port engine: address, sub-address, low byte then high byte
  // ----------------------------------------------------------------
  csar_port_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, sub_q, sub_d, lo_q, lo_d;
  logic [15:0] rd_word_q, rd_word_d;
  logic byte_hi_q, byte_hi_d, read_q, read_d, ack_ok_q, ack_ok_d;
  logic drive_q, drive_d, wr_stb_q, wr_stb_d;
  logic [15:0] state_reg_q, loop_reg_q, flags;

  wire byte_done = (cnt_q == CSAR_BITS_PER_BYTE);
  wire addr_hit = (shift_q[7:1] == P_DEV_ADDR);
  wire [7:0] rd_byte = byte_hi_q ? rd_word_q[15:8] : rd_word_q[7:0];
  // At a byte boundary cnt_q is 8, whose low bits select bit 7 first
  wire rd_bit = rd_byte[~cnt_q[2:0]];
  wire [15:0] wr_data = {shift_q, lo_q};
  wire sel_state = (sub_q == CSAR_OFS_STATE);
  wire sel_loop = (sub_q == CSAR_OFS_LOOP);
  wire sel_flags = (sub_q == CSAR_OFS_FLAGS);
  // Snapshot at address match so both bytes of a read come from one instant
  wire [15:0] read_mux = sel_state ? state_reg_q :
                         sel_loop ? loop_reg_q :
                         sel_flags ? flags : CSAR_READ_UNMAPPED;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    sub_d = sub_q;
    lo_d = lo_q;
    rd_word_d = rd_word_q;
    byte_hi_d = byte_hi_q;
    read_d = read_q;
    ack_ok_d = ack_ok_q;
    drive_d = drive_q;
    wr_stb_d = 1'b0;
    if (stop_det) begin
      state_d = CSAR_IDLE;
      drive_d = 1'b0;
    end else if (start_det) begin
      state_d = CSAR_ADDR;
      cnt_d = '0;
      drive_d = 1'b0;
    end else if (scl_rise) begin
      if ((state_q == CSAR_ADDR || state_q == CSAR_SUB || state_q == CSAR_WR) && !byte_done) begin
        shift_d = {shift_q[6:0], sda_s_q};
        cnt_d = cnt_q + 4'h1;
      end else if (state_q == CSAR_RD && !byte_done) begin
        cnt_d = cnt_q + 4'h1;
      end else if (state_q == CSAR_RD_ACK) begin
        ack_ok_d = ~sda_s_q;
        byte_hi_d = ~byte_hi_q;
      end
    end else if (scl_fall) begin
      unique case (state_q)
        CSAR_IDLE: begin
        end
        CSAR_ADDR: begin
          if (byte_done && addr_hit) begin
            state_d = CSAR_ACK_ADDR;
            drive_d = 1'b1;
            read_d = shift_q[0];
            rd_word_d = read_mux;
            byte_hi_d = 1'b0;
          end else if (byte_done) begin
            state_d = CSAR_IDLE;
          end
        end
        CSAR_ACK_ADDR: begin
          state_d = read_q ? CSAR_RD : CSAR_SUB;
          drive_d = read_q & ~rd_bit;
          cnt_d = '0;
        end
        CSAR_SUB: begin
          if (byte_done) begin
            sub_d = shift_q;
            state_d = CSAR_ACK_SUB;
            drive_d = 1'b1;
            byte_hi_d = 1'b0;
          end
        end
        CSAR_ACK_SUB: begin
          state_d = CSAR_WR;
          cnt_d = '0;
          drive_d = 1'b0;
        end
        CSAR_WR: begin
          if (byte_done) begin
            state_d = CSAR_ACK_WR;
            drive_d = 1'b1;
            wr_stb_d = byte_hi_q;
            lo_d = byte_hi_q ? lo_q : shift_q;
          end
        end
        CSAR_ACK_WR: begin
          state_d = CSAR_WR;
          cnt_d = '0;
          drive_d = 1'b0;
          byte_hi_d = ~byte_hi_q;
        end
        CSAR_RD: begin
          state_d = byte_done ? CSAR_RD_ACK : CSAR_RD;
          drive_d = ~byte_done & ~rd_bit;
        end
        CSAR_RD_ACK: begin
          state_d = ack_ok_q ? CSAR_RD : CSAR_IDLE;
          drive_d = ack_ok_q & ~rd_bit;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q <= CSAR_IDLE;
      {cnt_q, shift_q, sub_q, lo_q, rd_word_q} <= '0;
      {byte_hi_q, read_q, ack_ok_q, drive_q, wr_stb_q} <= '0;
    end else begin
      state_q <= state_d;
      {cnt_q, shift_q, sub_q, lo_q, rd_word_q} <= {cnt_d, shift_d, sub_d, lo_d, rd_word_d};
      {byte_hi_q, read_q, ack_ok_q, drive_q, wr_stb_q} <=
        {byte_hi_d, read_d, ack_ok_d, drive_d, wr_stb_d};
    end
  end

  // Open drain: only ever pull low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = drive_q;

  // ----------------------------------------------------------------
  // Charger state and active loop registers
  // ----------------------------------------------------------------
  wire phase_ok = (i_charge_phase <= CSAR_PH_LAST);
  // Encoding from a code makes two set bits impossible by construction
  wire [15:0] state_reg_d = phase_ok ? (CSAR_STATE_ONE << i_charge_phase) : '0;
  wire charging = state_reg_d[CSAR_ST_EQUALIZE] | state_reg_d[CSAR_ST_ABSORB] |
                  state_reg_d[CSAR_ST_PRECHARGE] |
                  state_reg_d[CSAR_ST_CONST_CURRENT_VOLTAGE_PHASE];
  // Fixed priority keeps the loop bits exclusive if several loops report at once
  wire loop_uvcl = charging & i_uvcl_loop;
  wire loop_iin = charging & ~i_uvcl_loop & i_iin_loop;
  wire loop_ichg = charging & ~i_uvcl_loop & ~i_iin_loop & i_icharge_loop;
  wire loop_vchg = charging & ~i_uvcl_loop & ~i_iin_loop & ~i_icharge_loop & i_vcharge_loop;
  logic [15:0] loop_reg_d;

  always_comb begin
    loop_reg_d = '0;
    loop_reg_d[CSAR_LOOP_UVCL] = loop_uvcl;
    loop_reg_d[CSAR_LOOP_IIN] = loop_iin;
    loop_reg_d[CSAR_LOOP_ICHARGE] = loop_ichg;
    loop_reg_d[CSAR_LOOP_VCHARGE] = loop_vchg;
  end

  // Serial writes never reach these two registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg_q <= '0;
      loop_reg_q <= '0;
    end else begin
      state_reg_q <= state_reg_d;
      loop_reg_q <= loop_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // Sticky limit flags
  // ----------------------------------------------------------------
  logic meas_prev_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      meas_prev_q <= 1'b0;
    end else begin
      meas_prev_q <= i_meas_valid;
    end
  end

  wire meas_rise = i_meas_valid & ~meas_prev_q;
  wire [15:0] cond = {meas_rise, 1'b0,
                      i_charge_count_low, i_charge_count_high,
                      i_battery_volt_low, i_battery_volt_high,
                      i_input_volt_low, i_input_volt_high,
                      i_system_volt_low, i_system_volt_high,
                      i_input_current_high,
                      i_battery_current_low,
                      i_chip_heat,
                      i_series_resistance_high,
                      i_cold_battery, i_hot_battery};
  wire flag_wr = wr_stb_q & sel_flags;
  // Only zero bits of the written word clear; ones leave the flag alone
  wire [15:0] flag_clr = flag_wr ? ~wr_data : '0;

  genvar gi;
  generate
    for (gi = 0; gi < CSAR_REG_W; gi++) begin : g_flag
      if (CSAR_FLAG_IMPL[gi]) begin : g_impl
        csar_flag_cell u_cell (
          .i_core_clk(i_core_clk),
          .i_reset(i_reset),
          .i_set(cond[gi]),
          .i_enable(i_limit_enable[gi]),
          .i_clear(flag_clr[gi]),
          .o_flag(flags[gi])
        );
      end else begin : g_rsvd
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  assign o_charger_state_onehot = state_reg_q;
  assign o_active_loop_status = loop_reg_q;
  assign o_measurement_limit_flags = flags;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  AST_STATE_ONEHOT: assert property ($onehot0(state_reg_q) && (state_reg_q & ~CSAR_STATE_IMPL) == '0)
    else $error("charger state not one-hot or reserved bit set");
  AST_STATE_MAP: assert property (phase_ok |=> state_reg_q == (CSAR_STATE_ONE << $past(i_charge_phase)))
    else $error("charger state bit does not match phase");
  AST_STATE_BAD: assert property (!phase_ok |=> state_reg_q == '0)
    else $error("unknown phase must clear state register");
  AST_LOOP_EXCL: assert property ($onehot0(loop_reg_q) && loop_reg_q[15:4] == '0)
    else $error("loop status bits not exclusive");
  AST_LOOP_IDLE: assert property (!charging |=> loop_reg_q == '0)
    else $error("loop status shown outside charging");
  AST_LOOP_UVCL: assert property (charging && i_uvcl_loop |=> loop_reg_q[CSAR_LOOP_UVCL])
    else $error("undervoltage loop not reported");
  AST_LOOP_CC: assert property (charging && !i_uvcl_loop && !i_iin_loop
    && i_icharge_loop |=> loop_reg_q[CSAR_LOOP_ICHARGE])
    else $error("charge current loop not reported");
  AST_FLAG_EN: assert property (##1 (flags & ~$past(i_limit_enable)) == '0)
    else $error("flag set while disabled");
  AST_FLAG_CLEAR: assert property (flag_wr && (cond & i_limit_enable) == '0
    |=> (flags & ~$past(wr_data)) == '0)
    else $error("zero write did not clear flag");
  AST_FLAG_STICKY: assert property (##1 ($past(flags) & ~flags & $past(i_limit_enable)
    & ~$past(flag_clr)) == '0)
    else $error("flag dropped without clear or disable");
  AST_FLAG_SET: assert property (##1 ($past(cond) & $past(i_limit_enable)
    & CSAR_FLAG_IMPL & ~flags) == '0)
    else $error("enabled condition did not set flag");
  AST_MEAS_SET: assert property (i_meas_valid && !meas_prev_q
    && i_limit_enable[CSAR_FLG_MEAS_VALID] |=> flags[CSAR_FLG_MEAS_VALID])
    else $error("measurement valid flag not set");
  AST_FLAG_RSVD: assert property ((flags & ~CSAR_FLAG_IMPL) == '0)
    else $error("reserved flag bit set");

  COV_READ: cover property (state_q == CSAR_RD_ACK && ack_ok_q);
  COV_WRITE_FLAGS: cover property (flag_wr);
  COV_SET_AND_CLEAR: cover property (flag_wr && (cond & i_limit_enable & ~wr_data) != '0);
  COV_CHARGING_LOOP: cover property (charging && loop_reg_d != '0);

endmodule

// ===== verif/csar_regs_tb.sv
// Self-checking testbench for the charger state, loop status and limit flag register bank
`timescale 1ns/1ps

module tb;
  import csar_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus, design and open-drain wire
  // ----------------------------------------------------------------
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic [3:0] phase = 4'h0;
  logic [3:0] loops = 4'h0;
  logic [15:0] enable = 16'h0000;
  logic [15:0] cond = 16'h0000;
  logic sda_oe;
  logic sda_out;
  logic [15:0] state_v;
  logic [15:0] loop_v;
  logic [15:0] flags_v;
  logic [15:0] exp_q[$];
  logic [15:0] got_q[$];
  logic [15:0] w_exp;
  logic [15:0] w_got;
  int seed = 32'h1485;
  int num_errors = 0;
  int n_compared = 0;
  // Pull-up: the wire is low whenever either side pulls it
  wire sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

  always #5 i_core_clk = ~i_core_clk;

  csar_regs i_dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_scl(scl_m), .i_sda(sda_line),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_charge_phase(phase),
    .i_uvcl_loop(loops[3]), .i_iin_loop(loops[2]), .i_icharge_loop(loops[1]),
    .i_vcharge_loop(loops[0]), .i_limit_enable(enable), .i_meas_valid(cond[15]),
    .i_charge_count_low(cond[13]), .i_charge_count_high(cond[12]),
    .i_battery_volt_low(cond[11]), .i_battery_volt_high(cond[10]),
    .i_input_volt_low(cond[9]), .i_input_volt_high(cond[8]),
    .i_system_volt_low(cond[7]), .i_system_volt_high(cond[6]),
    .i_input_current_high(cond[5]), .i_battery_current_low(cond[4]),
    .i_chip_heat(cond[3]), .i_series_resistance_high(cond[2]),
    .i_cold_battery(cond[1]), .i_hot_battery(cond[0]),
    .o_charger_state_onehot(state_v), .o_active_loop_status(loop_v),
    .o_measurement_limit_flags(flags_v)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic note(input logic [15:0] exp_v, input logic [15:0] got_v);
    exp_q.push_back(exp_v);
    got_q.push_back(got_v);
  endtask

  function automatic logic [15:0] exp_state(input logic [3:0] p);
    return (p <= 4'ha) ? (16'h0001 << p) : 16'h0000;
  endfunction

  function automatic logic [15:0] exp_loop(input logic [3:0] p, input logic [3:0] l);
    if (!(p == 4'ha || p == 4'h9 || p == 4'h7 || p == 4'h6)) return 16'h0000;
    if (l[3]) return 16'h0008;
    if (l[2]) return 16'h0004;
    if (l[1]) return 16'h0002;
    if (l[0]) return 16'h0001;
    return 16'h0000;
  endfunction

  // ----------------------------------------------------------------
  // Serial port master; SCL half periods of 10 clocks
  // ----------------------------------------------------------------
  task automatic sbit(input logic b, output logic r);
    sda_m = b;
    cyc(5);
    scl_m = 1'b1;
    cyc(10);
    r = sda_line;
    scl_m = 1'b0;
    cyc(5);
  endtask

  // Sends b, then drives the ninth bit with last; r holds what was on the wire
  task automatic sbyte(input logic [7:0] b, input logic last, output logic [7:0] r,
                       output logic ack);
    for (int i = 7; i >= 0; i--) sbit(b[i], r[i]);
    sbit(last, ack);
  endtask

  task automatic start;
    sda_m = 1'b1;
    cyc(5);
    scl_m = 1'b1;
    cyc(5);
    sda_m = 1'b0;
    cyc(5);
    scl_m = 1'b0;
    cyc(5);
  endtask

  task automatic stop;
    sda_m = 1'b0;
    cyc(5);
    scl_m = 1'b1;
    cyc(5);
    sda_m = 1'b1;
    cyc(5);
  endtask

  task automatic reg_wr(input logic [7:0] sub, input logic [15:0] d);
    logic [7:0] r;
    logic a;
    start();
    sbyte({CSAR_DEV_ADDR_DEF, 1'b0}, 1'b1, r, a);
    sbyte(sub, 1'b1, r, a);
    sbyte(d[7:0], 1'b1, r, a);
    sbyte(d[15:8], 1'b1, r, a);
    stop();
  endtask

  task automatic reg_rd(input logic [7:0] sub, output logic [15:0] d);
    logic [7:0] r;
    logic a;
    start();
    sbyte({CSAR_DEV_ADDR_DEF, 1'b0}, 1'b1, r, a);
    note(16'h0000, {15'h0000, a});
    sbyte(sub, 1'b1, r, a);
    start();
    sbyte({CSAR_DEV_ADDR_DEF, 1'b1}, 1'b1, r, a);
    sbyte(8'hff, 1'b0, d[7:0], a);
    sbyte(8'hff, 1'b1, d[15:8], a);
    stop();
  endtask

  // ----------------------------------------------------------------
  // Comparison and verdict
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    while (got_q.size() > 0) begin
      w_exp = exp_q.pop_front();
      w_got = got_q.pop_front();
      n_compared++;
      if (w_got !== w_exp) begin
        num_errors++;
        $display("unexpected value at %0t: got %h expected %h", $time, w_got, w_exp);
      end
    end
  end

  task automatic print_verdict;
    $display("compared %0d values, %0d mismatches", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs about 21600 clocks; nearly three times that means a hang
  initial begin
    cyc(60000);
    num_errors++;
    $display("unexpected stall at %0t: got %h expected %h", $time, 1'b1, 1'b0);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] rd;
    logic [15:0] mask;
    logic [7:0] r;
    logic a;
    cyc(20);
    note(16'h0000, state_v | loop_v | flags_v);
    i_reset = 1'b0;
    cyc(4);
    for (int n = 0; n < 32; n++) begin
      phase = n[3:0];
      loops = 4'($random(seed));
      cyc(2);
      note(exp_state(phase), state_v);
      note(exp_loop(phase, loops), loop_v);
    end
    phase = 4'h9;
    loops = 4'h3;
    cyc(2);
    reg_rd(CSAR_OFS_STATE, rd);
    note(16'h0200, rd);
    reg_rd(CSAR_OFS_LOOP, rd);
    note(16'h0002, rd);
    reg_wr(CSAR_OFS_STATE, 16'hffff);
    reg_wr(CSAR_OFS_LOOP, 16'hffff);
    note(16'h0200, state_v);
    note(16'h0002, loop_v);
    reg_rd(8'h50, rd);
    note(16'h0000, rd);
    start();
    sbyte({7'h15, 1'b0}, 1'b1, r, a);
    stop();
    note(16'h0001, {15'h0000, a});
    $display("test status registers done");
    // Each flag alone, bit 14 included to show it stays clear
    enable = 16'hffff;
    for (int i = 0; i < 16; i++) begin
      reg_wr(CSAR_OFS_FLAGS, 16'h0000);
      note(16'h0000, flags_v);
      cond = 16'h0001 << i;
      cyc(2);
      cond = 16'h0000;
      cyc(3);
      note((16'h0001 << i) & 16'hbfff, flags_v);
    end
    $display("test single flags done");
    cond = 16'hffff;
    cyc(2);
    cond = 16'h0000;
    cyc(3);
    note(16'hbfff, flags_v);
    reg_wr(CSAR_OFS_FLAGS, 16'hfffe);
    reg_rd(CSAR_OFS_FLAGS, rd);
    note(16'hbffe, rd);
    enable = 16'h7fff;
    cyc(2);
    note(16'h3ffe, flags_v);
    $display("test clear and disable done");
    for (int k = 0; k < 4; k++) begin
      mask = 16'($random(seed));
      enable = mask;
      reg_wr(CSAR_OFS_FLAGS, 16'h0000);
      cond = 16'($random(seed));
      cyc(2);
      note(cond & mask & 16'hbfff, flags_v);
      rd = cond & mask & 16'hbfff;
      cond = 16'h0000;
      cyc(3);
      note(rd, flags_v);
    end
    $display("test enable masks done");
    cyc(2);
    print_verdict();
  end

endmodule
